// [rtl/serial_rate_pkg.sv]
// Constants for the serial bit-rate generator and data buffer.
// Assumes an APB slave with 32-bit data and one aligned word per register.
// How it works
// - Data address reads received byte, writes transmit byte, separate stores.
// - Reset leaves both data bytes untouched.
// - One bit-rate enable clocks both receiver and transmitter.
// - No LIN bits gives plain port; receive LIN detects 13 or 14 bits.
// - Transmit LIN alone generates 13 or 14 low bits per length select.
// - Both LIN bits detect 13/14 and generate 11/12 low bits.
// - Reset clears LIN bits, coarse, power-of-two, prescale and fine fields.
// - Coarse code 0..3 selects divisor 1, 3, 4 or 13.
// - Rate select code n divides by two to the power n.
// - Prescale code 0 bypasses; codes 1..7 divide by code plus one.
// - With prescale code 1..7, fine code inserts that many extra clocks per 32 prescaler outputs.
// - Bit rate is source over 64, coarse, power-of-two and prescale terms.
// - Source is bus clock or crystal clock, chosen by an outside bit.
// - Transmit byte moves to shifter; received bytes move into buffer.
package serial_rate_pkg;
    localparam logic [11:0] data_buffer_addr = 12'h018;
    localparam logic [11:0] rate_control_addr = 12'h01c;
    localparam logic [11:0] prescale_control_addr = 12'h020;
    // Bit positions in the rate and LIN control register
    localparam int lin_tx_bit = 7;
    localparam int lin_rx_bit = 6;
    localparam int coarse_lsb = 4;
    localparam int pow2_lsb = 0;
    // Bit positions in the prescaler register
    localparam int prescale_lsb = 5;
    localparam int fine_lsb = 0;
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [3:0] coarse_div_1 = 4'h1;
    localparam logic [3:0] coarse_div_3 = 4'h3;
    localparam logic [3:0] coarse_div_4 = 4'h4;
    localparam logic [3:0] coarse_div_13 = 4'hd;
    localparam logic [5:0] oversample_div = 6'h3f; // 64 minus one
    localparam logic [4:0] break_bits_11 = 5'h0b;
    localparam logic [4:0] break_bits_12 = 5'h0c;
    localparam logic [4:0] break_bits_13 = 5'h0d;
    localparam logic [4:0] break_bits_14 = 5'h0e;
endpackage

// [rtl/serial_rate_buffer.sv]
// Serial data buffer, bit-rate divider chain and LIN break-length control.
// Assumes an APB master on clock and shift registers on the same clock.
`timescale 1ns/1ps
module serial_rate_buffer
    import serial_rate_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock source
    input wire logic crystal_clock_tick,
    input wire logic rate_clock_source_select,
    // Shift register side
    input wire logic tx_shift_load,
    input wire logic rx_shift_done,
    input wire logic [7:0] rx_shift_byte,
    input wire logic long_char_select,
    output logic [7:0] tx_shift_byte,
    output logic bit_rate_tick,
    output logic lin_rx_break_select,
    output logic lin_tx_break_select,
    output logic [4:0] rx_break_bits,
    output logic [4:0] tx_break_bits
);
    logic [7:0] rx_byte, next_rx_byte;
    logic [7:0] tx_byte, next_tx_byte;
    logic [7:0] rate_ctl, next_rate_ctl;
    logic [7:0] psc_ctl, next_psc_ctl;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic setup, access, wr, mapped, next_pready;

    // Coarse prescaler divisor lookup
    function automatic logic [3:0] coarse_div(input logic [1:0] code);
        unique case (code)
            2'h0: coarse_div = coarse_div_1;
            2'h1: coarse_div = coarse_div_3;
            2'h2: coarse_div = coarse_div_4;
            2'h3: coarse_div = coarse_div_13;
        endcase
    endfunction

    // APB decode; the answer is built in the setup cycle so that it is
    // registered by the edge that opens the access cycle and stands there
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign mapped = paddr == data_buffer_addr ||
        paddr == rate_control_addr || paddr == prescale_control_addr;

    // Register next values
    always_comb
    begin
        next_rx_byte = rx_byte;
        next_tx_byte = tx_byte;
        next_rate_ctl = rate_ctl;
        next_psc_ctl = psc_ctl;
        next_prdata = 32'h0;
        next_pready = setup;
        next_pslverr = setup && !mapped;
        if (rx_shift_done)
        begin
            next_rx_byte = rx_shift_byte;
        end
        // Writes land on the access edge; unmapped ones are dropped
        if (wr)
        begin
            unique case (paddr)
                data_buffer_addr: next_tx_byte = pwdata[7:0];
                rate_control_addr: next_rate_ctl = pwdata[7:0];
                prescale_control_addr: next_psc_ctl = pwdata[7:0];
                default: next_psc_ctl = psc_ctl;
            endcase
        end
        // Read data is fetched in setup, so a byte arriving during the
        // access cycle is seen by the next read, not this one
        if (setup && !pwrite)
        begin
            unique case (paddr)
                data_buffer_addr: next_prdata = {24'h0, rx_byte};
                rate_control_addr: next_prdata = {24'h0, rate_ctl};
                prescale_control_addr: next_prdata = {24'h0, psc_ctl};
                default: next_prdata = 32'h0;
            endcase
        end
        if (sys_rst)
        begin
            next_rate_ctl = control_reset;
            next_psc_ctl = control_reset;
        end
    end

    // Data bytes carry no reset
    always_ff @(posedge clock)
    begin
        rx_byte <= next_rx_byte;
        tx_byte <= next_tx_byte;
        rate_ctl <= next_rate_ctl;
        psc_ctl <= next_psc_ctl;
    end

    // APB answer registers, ready in the access cycle
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Field views
    logic [1:0] coarse_code;
    logic [2:0] pow2_code;
    logic [2:0] psc_code;
    logic [4:0] fine_code;
    assign coarse_code = rate_ctl[coarse_lsb +: 2];
    assign pow2_code = rate_ctl[pow2_lsb +: 3];
    assign psc_code = psc_ctl[prescale_lsb +: 3];
    assign fine_code = psc_ctl[fine_lsb +: 5];

    // Source select and fractional prescaler
    logic src_tick;
    logic [3:0] psc_cnt, next_psc_cnt;
    logic [4:0] frame_cnt, next_frame_cnt;
    logic stretch, next_stretch;
    logic psc_tick;
    // Bus clock counts every cycle; the crystal comes as a one-cycle enable
    assign src_tick = rate_clock_source_select ? crystal_clock_tick : 1'b1;

    always_comb
    begin
        next_psc_cnt = psc_cnt;
        next_frame_cnt = frame_cnt;
        next_stretch = stretch;
        psc_tick = 1'b0;
        if (src_tick)
        begin
            if (psc_code == 3'h0)
            begin
                psc_tick = 1'b1;
                next_psc_cnt = 4'h0;
            end
            else if (psc_cnt >= {1'b0, psc_code} + {3'h0, stretch})
            begin
                psc_tick = 1'b1;
                next_psc_cnt = 4'h0;
                next_frame_cnt = frame_cnt + 5'h1;
                // Insert one extra clock when fine*pos/32 steps up
                next_stretch = fine_mark(frame_cnt + 5'h1, fine_code);
            end
            else
            begin
                next_psc_cnt = psc_cnt + 4'h1;
            end
        end
    end

    // True on frame slots where the running fine*k/32 sum crosses a step
    function automatic logic fine_mark(input logic [4:0] k,
                                       input logic [4:0] f);
        logic [9:0] a;
        logic [9:0] b;
        a = 10'({5'h0, k} * {5'h0, f});
        b = 10'(({5'h0, k} + 10'h1) * {5'h0, f});
        fine_mark = (a[9:5] != b[9:5]);
    endfunction

    // Coarse, oversample and power-of-two chain
    logic [3:0] crs_cnt, next_crs_cnt;
    logic [5:0] os_cnt, next_os_cnt;
    logic [6:0] p2_cnt, next_p2_cnt;
    logic next_rate_tick;
    always_comb
    begin
        next_crs_cnt = crs_cnt;
        next_os_cnt = os_cnt;
        next_p2_cnt = p2_cnt;
        next_rate_tick = 1'b0;
        if (psc_tick)
        begin
            if (crs_cnt >= coarse_div(coarse_code) - 4'h1)
            begin
                next_crs_cnt = 4'h0;
                if (os_cnt == oversample_div)
                begin
                    next_os_cnt = 6'h0;
                    if (p2_cnt >= 7'((8'h1 << pow2_code) - 8'h1))
                    begin
                        next_p2_cnt = 7'h0;
                        next_rate_tick = 1'b1;
                    end
                    else
                    begin
                        next_p2_cnt = p2_cnt + 7'h1;
                    end
                end
                else
                begin
                    next_os_cnt = os_cnt + 6'h1;
                end
            end
            else
            begin
                next_crs_cnt = crs_cnt + 4'h1;
            end
        end
    end

    // LIN break lengths
    logic [4:0] next_rx_break, next_tx_break;
    always_comb
    begin
        next_rx_break = long_char_select ? break_bits_14 : break_bits_13;
        if (rate_ctl[lin_rx_bit])
        begin
            next_tx_break = long_char_select ? break_bits_12 : break_bits_11;
        end
        else
        begin
            next_tx_break = long_char_select ? break_bits_14 : break_bits_13;
        end
    end

    // Divider and output registers
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            psc_cnt <= 4'h0;
            frame_cnt <= 5'h0;
            stretch <= 1'b0;
            crs_cnt <= 4'h0;
            os_cnt <= 6'h0;
            p2_cnt <= 7'h0;
            bit_rate_tick <= 1'b0;
            lin_rx_break_select <= 1'b0;
            lin_tx_break_select <= 1'b0;
            rx_break_bits <= break_bits_13;
            tx_break_bits <= break_bits_13;
            tx_shift_byte <= 8'h0;
        end
        else
        begin
            psc_cnt <= next_psc_cnt;
            frame_cnt <= next_frame_cnt;
            stretch <= next_stretch;
            crs_cnt <= next_crs_cnt;
            os_cnt <= next_os_cnt;
            p2_cnt <= next_p2_cnt;
            bit_rate_tick <= next_rate_tick;
            lin_rx_break_select <= rate_ctl[lin_rx_bit];
            lin_tx_break_select <= rate_ctl[lin_tx_bit];
            rx_break_bits <= next_rx_break;
            tx_break_bits <= next_tx_break;
            if (tx_shift_load)
            begin
                tx_shift_byte <= tx_byte;
            end
        end
    end
endmodule

// [test/serial_rate_buffer_assertions.sv]
// Checker for APB answers, LIN break lengths and the bit-rate tick.
// Sees only the ports of serial_rate_buffer; attached by bind below.
`timescale 1ns/1ps
module serial_rate_buffer_assertions
    import serial_rate_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Length select input, rate and LIN outputs
    input wire logic long_char_select,
    input wire logic bit_rate_tick,
    input wire logic lin_rx_break_select,
    input wire logic lin_tx_break_select,
    input wire logic [4:0] rx_break_bits,
    input wire logic [4:0] tx_break_bits
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    logic mapped;
    // Decode of the three mapped words
    assign mapped = paddr == data_buffer_addr || paddr == rate_control_addr
        || paddr == prescale_control_addr;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    a_ready_first: assert property (setup_s |=> pready)
        else $error("pready late");
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready held");
    a_unmapped_err: assert property ((access_s and !mapped) |->
        pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_mapped_ok: assert property ((access_s and mapped) |-> !pslverr &&
        prdata[31:8] == 24'h0) else $error("mapped access refused");
    a_lin_copy: assert property ((access_s and (pwrite &&
        paddr == rate_control_addr)) |-> ##2
        lin_tx_break_select == $past(pwdata[lin_tx_bit], 2) &&
        lin_rx_break_select == $past(pwdata[lin_rx_bit], 2))
        else $error("LIN select not copied");
    a_tx_break_len: assert property (lin_tx_break_select &&
        $stable(long_char_select) |-> tx_break_bits == (lin_rx_break_select ?
        (long_char_select ? break_bits_12 : break_bits_11) :
        (long_char_select ? break_bits_14 : break_bits_13)))
        else $error("tx break length wrong");
    a_rx_break_len: assert property (lin_rx_break_select &&
        $stable(long_char_select) |-> rx_break_bits ==
        (long_char_select ? break_bits_14 : break_bits_13))
        else $error("rx break length wrong");
    a_tick_gap: assert property (bit_rate_tick |=>
        (!bit_rate_tick) [*8]) else $error("tick too soon");
endmodule
bind serial_rate_buffer serial_rate_buffer_assertions
    serial_rate_buffer_assertions_i (.clock, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .long_char_select, .bit_rate_tick, .lin_rx_break_select,
    .lin_tx_break_select, .rx_break_bits, .tx_break_bits);

// [test/serial_shift_model.sv]
// Model of the transmit and receive shift registers beside the block.
// Its tasks are called by the bench; all on the shared clock.
`timescale 1ns/1ps
module serial_shift_model
(
    // Clock
    input wire logic clock,
    // Shift register handshake
    input wire logic [7:0] tx_shift_byte,
    output logic tx_shift_load,
    output logic rx_shift_done,
    output logic [7:0] rx_shift_byte,
    output logic [7:0] tx_seen
);
    // Idle levels
    initial
    begin
        tx_shift_load = 1'b0;
        rx_shift_done = 1'b0;
        rx_shift_byte = 8'h00;
        tx_seen = 8'h00;
    end
    // Hand a byte over, then scramble the byte lines
    task automatic receive(input logic [7:0] b);
        @(posedge clock);
        rx_shift_done <= 1'b1;
        rx_shift_byte <= b;
        @(posedge clock);
        rx_shift_done <= 1'b0;
        rx_shift_byte <= ~b;
    endtask
    // Pull the transmit byte into the shifter
    task automatic load;
        @(posedge clock);
        tx_shift_load <= 1'b1;
        @(posedge clock);
        tx_shift_load <= 1'b0;
        // The byte is registered at the edge that saw the load
        @(posedge clock);
        tx_seen = tx_shift_byte;
    endtask
endmodule

// [test/serial_rate_buffer_tb.sv]
// Bench for the serial rate block: APB master, periods, LIN lengths.
// The shift model plays the shift registers.
`timescale 1ns/1ps
module serial_rate_buffer_tb
    import serial_rate_pkg::*;
;
    logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic xtal = 0, src = 0, longc = 0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic ld, done, tk, lrx, ltx;
    logic [7:0] rxb, txb, tx_seen;
    logic [4:0] rbits, tbits;
    int miscompares = 0, n_tests = 0, cdiv[4] = '{1, 3, 4, 13};
    serial_rate_buffer serial_rate_buffer_i (.clock(clock), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crystal_clock_tick(xtal), .rate_clock_source_select(src),
        .tx_shift_load(ld), .rx_shift_done(done), .rx_shift_byte(rxb),
        .long_char_select(longc), .tx_shift_byte(txb), .bit_rate_tick(tk),
        .lin_rx_break_select(lrx), .lin_tx_break_select(ltx),
        .rx_break_bits(rbits), .tx_break_bits(tbits));
    serial_shift_model serial_shift_model_i (.clock(clock), .tx_shift_byte(txb),
        .tx_shift_load(ld), .rx_shift_done(done), .rx_shift_byte(rxb),
        .tx_seen(tx_seen));
    // Clock, and a crystal tick every other cycle
    initial
    begin
        forever #10 clock = ~clock;
    end
    always @(posedge clock) xtal <= ~xtal;
    task automatic final_report;
        $display("miscompares %0d n_tests %0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic hang;
        miscompares++;
        $display("CHECK FAILED %0t wait ran out", $time);
        final_report;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        chk(32'(got), 32'(exp));
    endtask
    // One APB transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            hang;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Cycles between two ticks, after one tick to settle
    task automatic period(input int e);
        int c;
        repeat (2)
        begin
            c = 0;
            do
            begin
                @(posedge clock);
                c++;
            end
            while (tk !== 1'b1 && c < 20000);
            if (c >= 20000)
                hang;
        end
        chk_n(c, e);
    endtask
    // Main sequence; data word is never read-modified-written
    initial
    begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        apb(0, rate_control_addr, 0);
        chk(rd, 32'h0);
        period(64);
        apb(1, data_buffer_addr, 'h5a);
        serial_shift_model_i.receive(8'h3c);
        apb(0, data_buffer_addr, 0);
        chk(rd, 32'h3c);
        serial_shift_model_i.load();
        chk(32'(tx_seen), 32'h5a);
        apb(1, rate_control_addr, 'hb5);
        apb(1, prescale_control_addr, 'hff);
        apb(0, prescale_control_addr, 0);
        chk(rd, 32'hff);
        apb(0, 12'h024, 0);
        chk({rd[31:1], err}, 32'h1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        apb(0, data_buffer_addr, 0);
        chk(rd, 32'h3c);
        serial_shift_model_i.load();
        chk(32'(tx_seen), 32'h5a);
        apb(0, rate_control_addr, 0);
        chk(rd, 32'h0);
        apb(0, prescale_control_addr, 0);
        chk(rd, 32'h0);
        // Divider chain, bypass switched while the divider runs
        for (int i = 0; i < 4; i++)
        begin
            apb(1, rate_control_addr, i << coarse_lsb);
            period(64 * cdiv[i]);
        end
        for (int i = 0; i < 8; i++)
        begin
            apb(1, rate_control_addr, i);
            period(64 << i);
        end
        for (int i = 0; i < 8; i++)
        begin
            apb(1, rate_control_addr, 1);
            apb(1, prescale_control_addr, i << prescale_lsb);
            period(128 * (i == 0 ? 1 : i + 1));
        end
        apb(1, rate_control_addr, 0);
        apb(1, prescale_control_addr, 'h30);
        period(160);
        apb(1, prescale_control_addr, 'h1f);
        period(64);
        apb(1, rate_control_addr, 'h31);
        apb(1, prescale_control_addr, 'h40);
        period(4992);
        apb(1, rate_control_addr, 0);
        apb(1, prescale_control_addr, 0);
        src <= 1'b1;
        period(128);
        src <= 1'b0;
        // Break lengths; software still times breaks itself
        for (int i = 0; i < 8; i++)
        begin
            longc <= i[0];
            apb(1, rate_control_addr, i[2:1] << lin_rx_bit);
            apb(0, rate_control_addr, 0);
            chk(32'({ltx, lrx}), 32'(i[2:1]));
            if (i[1])
                chk(32'(rbits), i[0] ? 14 : 13);
            if (i[2])
                chk(32'(tbits), i[1] ? 11 + i[0] : 13 + i[0]);
        end
        final_report;
    end
endmodule
